//--- hw/sbl_master.v
// two-wire bus master with eeprom autoload and received-byte fifo
`timescale 1ns/10ps
`include "sbl_map.vh"

module sbl_fifo #(
    parameter WIDTH = `SBL_FIFO_W,
    parameter DEPTH = `SBL_FIFO_D,
    parameter AW    = `SBL_FIFO_AW
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             ce,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wp;
    reg [AW-1:0]    rp;
    reg [AW:0]      cnt;
    wire            push;
    wire            pop;

    assign in_ready  = (cnt != DEPTH);
    assign out_valid = (cnt != 0);
    assign out_data  = mem[rp];
    assign push      = ce & in_valid & in_ready;
    assign pop       = ce & out_valid & out_ready;

    // storage has no reset; only pointers and fill count need one
    always @(posedge clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    // pointers and fill count
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp  <= {AW{1'b0}};
            rp  <= {AW{1'b0}};
            cnt <= {(AW+1){1'b0}};
        end else begin
            if (push) wp <= wp + 1'b1;
            if (pop)  rp <= rp + 1'b1;
            if (push & !pop)      cnt <= cnt + 1'b1;
            else if (pop & !push) cnt <= cnt - 1'b1;
        end
    end
endmodule

module sbl_master #(
    parameter QTR = `SBL_QTR_CYC
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       ce,
    input  wire       scl_in,
    output reg        scl_out,
    output reg        scl_oe,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe,
    input  wire       sw_go,
    input  wire [6:0] sw_slave,
    input  wire       sw_dir,
    input  wire [7:0] sw_index,
    input  wire [7:0] sw_wdata,
    output reg        busy,
    output reg        err,
    input  wire       err_clr,
    output reg  [7:0] rx_data,
    output reg        rx_valid,
    input  wire       rx_ready,
    output reg        load_done,
    output reg        load_ok,
    output reg  [7:0] cmd_f0,
    output reg  [7:0] cmd_f1,
    output reg [31:0] subsys_id,
    output reg [31:0] legacy_base
);
    // bus phases, one-hot
    localparam S_IDLE  = 9'h001;
    localparam S_START = 9'h002;
    localparam S_TX    = 9'h004;
    localparam S_TXACK = 9'h008;
    localparam S_RX    = 9'h010;
    localparam S_RXACK = 9'h020;
    localparam S_STOP  = 9'h040;
    localparam S_RSTRT = 9'h080;
    localparam S_SENSE = 9'h100;

    // synchronisers for the open-drain lines
    reg       scl_s1;
    reg       scl_s2;
    reg       sda_s1;
    reg       sda_s2;
    reg [8:0] state;
    reg [15:0] tick;
    reg [1:0] ph;
    reg [2:0] bitn;
    reg [7:0] sh;
    reg [2:0] step;
    reg       auto;
    reg       dir;
    reg [6:0] slave;
    reg [7:0] idx;
    reg [7:0] wdat;
    reg [3:0] bcnt;
    reg       last;
    wire      qend;
    wire      f_ready;
    wire [7:0] f_data;
    wire      f_valid;
    reg       f_push;

    // phase tick: four quarters per scl period keeps the rate at 100 kHz
    assign qend = (tick == QTR - 1);

    sbl_fifo #(
        .WIDTH (`SBL_FIFO_W),
        .DEPTH (`SBL_FIFO_D),
        .AW    (`SBL_FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_data   (sh),
        .in_valid  (f_push),
        .in_ready  (f_ready),
        .out_data  (f_data),
        .out_valid (f_valid),
        .out_ready (rx_ready | ~rx_valid)
    );

    // two-flop synchronisers; only stage two is looked at
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
        end else if (ce) begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
        end
    end

    // registered fifo output stage, so rx outputs come from flops
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_data  <= 8'h00;
            rx_valid <= 1'b0;
        end else if (ce) begin
            if (rx_ready | ~rx_valid) begin
                rx_valid <= f_valid;
                // hold the last byte rather than pull unwritten storage
                if (f_valid) rx_data <= f_data;
            end
        end
    end

    // main sequencer; bit timing runs in quarters, data and ack on sda move in quarter 0
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_SENSE;
            tick <= 16'h0000; ph <= 2'h0; bitn <= 3'h0; sh <= 8'h00;
            step <= 3'h0; auto <= 1'b1; dir <= 1'b0; slave <= 7'h00;
            idx <= 8'h00; wdat <= 8'h00; bcnt <= 4'h0; last <= 1'b0;
            f_push <= 1'b0;
            scl_out <= 1'b0; scl_oe <= 1'b0;
            sda_out <= 1'b0; sda_oe <= 1'b0;
            busy <= 1'b1; err <= 1'b0;
            load_done <= 1'b0; load_ok <= 1'b0;
            cmd_f0 <= 8'h00; cmd_f1 <= 8'h00;
            subsys_id <= 32'h0; legacy_base <= 32'h0;
        end else if (ce) begin
            f_push <= 1'b0;
            if (err_clr) err <= 1'b0;
            tick <= qend ? 16'h0000 : tick + 16'h0001;
            if (qend) ph <= ph + 2'h1;
            case (state)
            S_SENSE: begin
                // released scl reads high only through a pull-up
                if (qend && ph == 2'h3) begin
                    if (scl_s2) begin
                        slave <= `SBL_EE_ADDR;
                        dir <= `SBL_DIR_WR; idx <= `SBL_FUNC_OFS;
                        bcnt <= 4'h0; step <= 3'h0;
                        state <= S_START;
                    end else begin
                        auto <= 1'b0; busy <= 1'b0; load_done <= 1'b1;
                        state <= S_IDLE;
                    end
                end
            end
            S_IDLE: begin
                scl_oe <= 1'b0; sda_oe <= 1'b0;
                tick <= 16'h0000; ph <= 2'h0;
                if (sw_go) begin
                    slave <= sw_slave; dir <= sw_dir; idx <= sw_index;
                    wdat <= sw_wdata; auto <= 1'b0; step <= 3'h0;
                    busy <= 1'b1; state <= S_START;
                end
            end
            S_START, S_RSTRT: begin
                // q0 release sda, q1 scl high, q2 sda low, q3 scl low
                if (qend) begin
                    case (ph)
                    2'h0: sda_oe <= 1'b0;
                    2'h1: scl_oe <= 1'b0;
                    2'h2: sda_oe <= 1'b1;
                    default: begin
                        scl_oe <= 1'b1;
                        // the index always goes out first, so a plain start
                        // carries write and only the restart carries read
                        sh <= {slave, (state == S_RSTRT) ? `SBL_DIR_RD
                               : `SBL_DIR_WR};
                        bitn <= 3'h7; state <= S_TX;
                    end
                    endcase
                end
            end
            S_TX, S_TXACK, S_RX, S_RXACK: begin
                if (qend) begin
                    case (ph)
                    2'h0: begin // scl low here: only now sda may move
                        if (state == S_TX)
                            sda_oe <= ~sh[bitn];
                        else if (state == S_RXACK)
                            sda_oe <= ~last;
                        else
                            sda_oe <= 1'b0;
                    end
                    2'h1: scl_oe <= 1'b0;
                    2'h2: begin
                        if (state == S_RX) sh[bitn] <= sda_s2;
                        if (state == S_TXACK && sda_s2) begin
                            err <= 1'b1;
                        end
                    end
                    default: begin
                        scl_oe <= 1'b1;
                        bitn <= bitn - 3'h1;
                        if (state == S_TX && bitn == 3'h0) begin
                            state <= S_TXACK;
                        end else if (state == S_RX && bitn == 3'h0) begin
                            // loader bytes go to registers, never to the fifo
                            state <= S_RXACK;
                            f_push <= f_ready & ~auto;
                        end else if (state == S_TXACK) begin
                            bitn <= 3'h7;
                            // only this slot's nak aborts; a stale sticky
                            // error must not kill a fresh transfer
                            if (sda_s2) begin
                                state <= S_STOP;
                            end else if (step == 3'h0) begin
                                sh <= idx; step <= 3'h1; state <= S_TX;
                            end else if (step == 3'h1 &&
                                         (dir == `SBL_DIR_RD || auto)) begin
                                step <= 3'h2; state <= S_RSTRT;
                            end else if (step == 3'h1) begin
                                sh <= wdat; step <= 3'h2; state <= S_TX;
                            end else if (dir == `SBL_DIR_RD || auto) begin
                                // read address taken: the slave sends now
                                step <= 3'h3; state <= S_RX;
                            end else begin
                                state <= S_STOP;
                            end
                        end else if (state == S_RXACK) begin
                            bitn <= 3'h7;
                            if (auto) begin
                                case (bcnt)
                                4'h0: if (sh != `SBL_FUNC_IND) err <= 1'b1;
                                4'h1: if (sh != `SBL_NBYTE_IND) err <= 1'b1;
                                4'h2: cmd_f0 <= sh & `SBL_CMD_MASK;
                                4'h3: cmd_f1 <= sh & `SBL_CMD_MASK;
                                4'h4: subsys_id[7:0]   <= sh;
                                4'h5: subsys_id[15:8]  <= sh;
                                4'h6: subsys_id[23:16] <= sh;
                                4'h7: subsys_id[31:24] <= sh;
                                4'h8: legacy_base[7:0] <= sh & `SBL_BAR_MASK;
                                4'h9: legacy_base[15:8]  <= sh;
                                4'ha: legacy_base[23:16] <= sh;
                                default: legacy_base[31:24] <= sh;
                                endcase
                                bcnt <= bcnt + 4'h1;
                            end
                            state <= last ? S_STOP : S_RX;
                        end
                        if (state == S_TX && bitn == 3'h0) last <= 1'b0;
                        if (state == S_TXACK) begin
                            last <= ~auto;
                        end
                        if (state == S_RX && bitn == 3'h0 && auto) begin
                            last <= (bcnt == `SBL_LOAD_BYTES - 4'h1);
                        end
                    end
                    endcase
                end
            end
            S_STOP: begin
                // q0 hold sda low, q1 scl high, q2 sda rises, q3 free
                if (qend) begin
                    case (ph)
                    2'h0: sda_oe <= 1'b1;
                    2'h1: scl_oe <= 1'b0;
                    2'h2: sda_oe <= 1'b0;
                    default: begin
                        busy <= 1'b0;
                        if (auto) begin
                            load_done <= 1'b1;
                            load_ok <= ~err;
                            auto <= 1'b0;
                        end
                        state <= S_IDLE;
                    end
                    endcase
                end
            end
            default: state <= S_IDLE;
            endcase
        end
    end
endmodule

//--- hw/sbl_map.vh
// constants for the serial-bus master and eeprom loader
`ifndef SBL_MAP_VH
`define SBL_MAP_VH
`define SBL_CLK_HZ        200000000
`define SBL_SCL_HZ        100000
`define SBL_QTR_CYC       ((`SBL_CLK_HZ / `SBL_SCL_HZ) / 4)
`define SBL_EE_ADDR       7'h50
`define SBL_DIR_WR        1'b0
`define SBL_DIR_RD        1'b1
`define SBL_FUNC_OFS      8'h00
`define SBL_FUNC_IND      8'h00
`define SBL_NBYTE_IND     8'h20
`define SBL_LOAD_BYTES    4'hc
`define SBL_CMD_MASK      8'he7
`define SBL_BAR_MASK      8'hfe
`define SBL_FIFO_W        8
`define SBL_FIFO_D        8
`define SBL_FIFO_AW       3
`endif

//--- verification/sbl_ee_model.sv
// behavioural serial eeprom standing on the far side of the two-wire bus
`timescale 1ns/10ps
module sbl_ee_model #(
    parameter [6:0] DEV = 7'h50
) (
    input  wire scl,
    input  wire sda,
    output wire sda_oe
);
    reg [7:0] mem [0:255];
    reg [7:0] sh;
    reg [7:0] ptr = 8'h00;
    reg [3:0] cnt = 4'h0;
    reg       act = 1'b0;
    reg       rd = 1'b0;
    reg       mack = 1'b0;
    reg       drv = 1'b0;
    integer   nb = 0;
    assign sda_oe = drv;
    // start or repeated start; wait for the first scl fall before counting
    always @(negedge sda) if (scl) {act, cnt, nb} = {1'b1, 4'h9, 32'd0};
    always @(posedge sda) if (scl) act = 1'b0; // stop
    // sample on scl rise; in the ack slot note whether the master acked
    always @(posedge scl) begin
        if (act && cnt < 4'h8)
            sh = {sh[6:0], sda};
        if (act && cnt == 4'h8)
            mack = !sda;
    end
    // drive only a little after scl falls, so sda never moves with scl high
    always @(negedge scl) if (act) begin
        if (cnt == 4'h9)
            cnt = 4'h0;
        else if (cnt < 4'h7) begin
            cnt = cnt + 4'h1;
            if (rd && nb > 0)
                drv <= #5 !sh[7];
        end else if (cnt == 4'h7) begin
            cnt = 4'h8;
            if (rd && nb > 0) begin
                ptr = ptr + 8'h01;
                drv <= #5 1'b0; // the master answers this slot
            end else if (nb == 0 && sh[7:1] != DEV)
                act = 1'b0; // not addressed: no ack, stay silent
            else begin
                if (nb == 0)
                    rd = sh[0];
                else if (nb == 1)
                    ptr = sh;
                else
                    mem[ptr] = sh;
                drv <= #5 1'b1;
            end
        end else begin
            {cnt, nb} = {4'h0, nb + 1};
            sh = mem[ptr]; // contents laid out by the bench
            drv <= #5 (rd && (nb == 1 || mack)) ? !sh[7] : 1'b0;
        end
    end
endmodule

//--- verification/sbl_master_properties.sv
// port assertions for the two-wire bus master
`timescale 1ns/10ps
module sbl_master_chk #(
    parameter QTR = 500
) (
    input wire       clk,
    input wire       rst_n,
    input wire       scl_oe,
    input wire       sda_oe,
    input wire       busy,
    input wire       err,
    input wire       err_clr,
    input wire       sw_go,
    input wire       rx_valid,
    input wire       rx_ready,
    input wire [7:0] rx_data,
    input wire       load_done
);
    localparam int LQ = QTR + 1;
    localparam int LS = 2 * QTR + 2;
    reg [15:0] lo_cnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // length of each low phase of scl; a short one would overrun the rate
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            lo_cnt <= 16'h0000;
        else
            lo_cnt <= scl_oe ? lo_cnt + 16'h0001 : 16'h0000;
    end
    start_cond_a: assert property (
        $rose(sda_oe) && !scl_oe |-> ##[1:LQ] scl_oe)
        else $error("start not followed by scl low");
    stop_cond_a: assert property (
        $fell(sda_oe) && !scl_oe |-> ##[1:LS] !busy)
        else $error("sda release with scl high did not end transfer");
    sda_hold_a: assert property (
        $changed(sda_oe) && !scl_oe |=> !scl_oe [*3])
        else $error("sda moved near an scl edge");
    idle_release_a: assert property (
        !busy |-> !scl_oe && !sda_oe)
        else $error("line driven while idle");
    scl_low_a: assert property (
        $fell(scl_oe) |-> lo_cnt == 2 * QTR)
        else $error("scl low phase has wrong length");
    err_hold_a: assert property (
        err && !err_clr |=> err)
        else $error("error flag lost without clear");
    rx_hold_a: assert property (
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("received byte changed before taken");
    go_launch_a: assert property (
        sw_go && !busy |=> busy)
        else $error("launch not taken");
    busy_cause_a: assert property (
        $rose(busy) |-> $past(sw_go))
        else $error("transfer started without launch");
    load_hold_a: assert property (
        load_done |=> load_done)
        else $error("load done dropped");
endmodule

bind sbl_master sbl_master_chk #(.QTR(QTR)) u_chk (.clk, .rst_n, .scl_oe,
    .sda_oe, .busy, .err, .err_clr, .sw_go, .rx_valid, .rx_ready, .rx_data,
    .load_done);

//--- verification/tb_sbl_master.sv
// self-checking bench for the two-wire master and its eeprom autoload
`timescale 1ns/10ps
module tb_sbl_master;
    reg         clk, rst_n, scl_pu, sw_go, sw_dir, err_clr, rx_ready;
    reg  [6:0]  sw_slave;
    reg  [7:0]  sw_index, sw_wdata;
    wire        scl_oe, sda_oe, ee_oe, busy, err, rx_valid, load_done, load_ok;
    wire [7:0]  rx_data, cmd_f0, cmd_f1;
    wire [31:0] subsys_id, legacy_base;
    wire        scl_o, sda_o;
    wire        scl = scl_oe ? 1'b0 : scl_pu; // pull-up only when fitted
    wire        sda = ~(sda_oe | ee_oe);
    integer     bad_count = 0;
    integer     n_checks = 0;
    integer     i;
    sbl_master #(.QTR(4)) u_sbl_master (.clk, .rst_n, .ce(1'b1), .scl_in(scl),
        .scl_out(scl_o), .scl_oe, .sda_in(sda), .sda_out(sda_o), .sda_oe,
        .sw_go, .sw_slave, .sw_dir, .sw_index, .sw_wdata, .busy, .err,
        .err_clr,
        .rx_data, .rx_valid, .rx_ready, .load_done, .load_ok, .cmd_f0,
        .cmd_f1, .subsys_id, .legacy_base);
    sbl_ee_model u_ee (.scl(scl), .sda(sda), .sda_oe(ee_oe));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task check(input string nm, input [31:0] seen, input [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task go(input [6:0] s, input d, input [7:0] ix, input [7:0] wd);
        {sw_slave, sw_dir, sw_index, sw_wdata} = {s, d, ix, wd};
        sw_go = 1'b1;
        tick(1);
        sw_go = 1'b0;
        tick(1);
    endtask
    task wait_idle;
        for (i = 0; i < 3000 && busy !== 1'b0; i = i + 1)
            tick(1);
        check("busy", busy, 0);
    endtask
    task clear_err;
        err_clr = 1'b1;
        tick(1);
        err_clr = 1'b0;
        tick(1);
        check("err clear", err, 0);
    endtask
    // reset with or without the scl pull-up, then wait for the loader
    task do_reset(input pu);
        rst_n = 1'b0;
        scl_pu = pu;
        tick(3);
        rst_n = 1'b1;
        for (i = 0; i < 8000 && load_done !== 1'b1; i = i + 1)
            tick(1);
        check("load_done", load_done, 1);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        {rst_n, scl_pu, sw_go, sw_dir, err_clr, rx_ready} = 6'b010000;
        {sw_slave, sw_index, sw_wdata} = 23'h000000;
        for (i = 0; i < 256; i = i + 1)
            u_ee.mem[i] = 8'h11 * i[7:0];
        {u_ee.mem[1], u_ee.mem[2], u_ee.mem[3]} = 24'h21ff18; // bad count
        u_ee.mem[8] = 8'h89;
        // no pull-up on scl: the loader must skip the eeprom
        do_reset(1'b0);
        check("busy", busy, 0);
        check("scl idle", scl_oe, 0);
        check("open drain", {scl_o, sda_o}, 0);
        // header byte count wrong: load flagged, error raised, then cleared
        do_reset(1'b1);
        check("load_ok", load_ok, 0);
        check("err", err, 1);
        clear_err;
        $display("reset and header tests done");
        u_ee.mem[1] = 8'h20;
        do_reset(1'b1);
        check("load_ok", load_ok, 1);
        check("cmd_f0", cmd_f0, 8'he7);
        check("cmd_f1", cmd_f1, 8'h00);
        check("subsys", subsys_id, 32'h77665544);
        check("legacy", legacy_base, 32'hbbaa9988);
        $display("autoload test done");
        // byte write, with a second launch thrown at it while busy
        go(7'h50, 1'b0, 8'h30, 8'ha5);
        check("busy", busy, 1);
        go(7'h50, 1'b0, 8'h31, 8'h3c);
        wait_idle;
        check("wr byte", u_ee.mem[8'h30], 8'ha5);
        check("refused", u_ee.mem[8'h31], 8'h41);
        check("err", err, 0);
        go(7'h33, 1'b0, 8'h00, 8'h00);
        wait_idle;
        check("nak err", err, 1);
        clear_err;
        $display("write and nak tests done");
        // ten reads, consumer stalled: output stage plus fifo hold nine,
        // so the tenth byte is dropped
        for (integer r = 0; r < 10; r = r + 1) begin
            u_ee.mem[8'h40 + r[7:0]] = 8'hc0 + r[7:0];
            go(7'h50, 1'b1, 8'h40 + r[7:0], 8'h00);
            wait_idle;
        end
        check("err", err, 0);
        for (integer r = 0; r < 9; r = r + 1) begin
            check("rx valid", rx_valid, 1);
            check("rx data", rx_data, 8'hc0 + r);
            rx_ready = 1'b1;
            tick(1);
            rx_ready = 1'b0;
            tick(2);
        end
        check("rx empty", rx_valid, 0);
        $display("read and buffer test done");
        finish_test;
    end
    initial begin
        #400000;
        bad_count = bad_count + 1;
        finish_test;
    end
endmodule
